// *** core/intflag_pkg.sv ***
// Constants for the interrupt flag and edge control block
package intflag_pkg;

  // ==========================================================================
  // Register byte addresses (offsets not printed, chosen here)
  localparam logic [3:0] ADDR_CONTROL_TWO = 4'h0;
  localparam logic [3:0] ADDR_FLAGS_A     = 4'h4;
  localparam logic [3:0] ADDR_FLAGS_B     = 4'h8;

  // ==========================================================================
  // Control register two layout
  localparam int          ALT_TABLE_BIT  = 15;
  localparam int          HOLD_BIT       = 14;
  localparam int          EDGE_POL_LSB   = 0;
  localparam int          NUM_EXT_PINS   = 3;
  localparam logic [15:0] CONTROL_WMASK  = 16'h8007;
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;

  // ==========================================================================
  // Flag register layouts: implemented bits, all others read as zero
  localparam logic [15:0] FLAGS_A_MASK   = 16'h7fef;
  localparam logic [15:0] FLAGS_B_MASK   = 16'he87f;
  localparam logic [15:0] FLAGS_RESET    = 16'h0000;
  localparam int          FLAG_WIDTH     = 16;

  // Flag A positions
  localparam int FA_I2C_MASTER = 14;
  localparam int FA_I2C_SLAVE  = 13;
  localparam int FA_NVM        = 12;
  localparam int FA_ADC        = 11;
  localparam int FA_UART_TX    = 10;
  localparam int FA_UART_RX    = 9;
  localparam int FA_SPI        = 8;
  localparam int FA_TIMER3     = 7;
  localparam int FA_TIMER2     = 6;
  localparam int FA_COMPARE2   = 5;
  localparam int FA_TIMER1     = 3;
  localparam int FA_COMPARE1   = 2;
  localparam int FA_CAPTURE1   = 1;
  localparam int FA_EXT0       = 0;

  // Flag B positions
  localparam int FB_COMPARATOR3 = 15;
  localparam int FB_COMPARATOR2 = 14;
  localparam int FB_COMPARATOR1 = 13;
  localparam int FB_CHANGE      = 11;
  localparam int FB_PULSE_LSB   = 3;
  localparam int FB_PULSE_MATCH = 2;
  localparam int FB_EXT2        = 1;
  localparam int FB_EXT1        = 0;

  // ==========================================================================
  // AXI4-Lite answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : intflag_pkg

// *** core/intflag_ctrl.sv ***
// Interrupt control register two and flag registers A and B
// ==========================================================================
`timescale 1ns/1ps

module intflag_ctrl (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // AXI4-Lite write address
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Core status and vector table choice
  input  wire logic        HOLD_INSTR_ACTIVE,
  output logic             ALT_TABLE_SELECT,
  // External pins, already synchronous
  input  wire logic [2:0]  EXT_PIN,
  // Peripheral request pulses, one per flag position
  input  wire logic [15:0] REQ_FLAGS_A,
  input  wire logic [15:0] REQ_FLAGS_B,
  // Enables and priority gate from the remaining controller
  input  wire logic [15:0] ENABLE_A,
  input  wire logic [15:0] ENABLE_B,
  input  wire logic        PRIORITY_OK,
  // Outputs toward the core
  output logic [15:0]      FLAGS_A,
  output logic [15:0]      FLAGS_B,
  output logic             IRQ_PENDING,
  output logic             WAKE_REQUEST
);

  localparam int NP = intflag_pkg::NUM_EXT_PINS;

  // ==========================================================================
  // Bus slave state
  logic          aw_held_ff;
  logic          nxt_aw_held;
  logic [3:0]    aw_addr_ff;
  logic [3:0]    nxt_aw_addr;
  logic          w_held_ff;
  logic          nxt_w_held;
  logic [31:0]   w_data_ff;
  logic [31:0]   nxt_w_data;
  logic [3:0]    w_strb_ff;
  logic [3:0]    nxt_w_strb;
  logic          bvalid_ff;
  logic          nxt_bvalid;
  logic [1:0]    bresp_ff;
  logic [1:0]    nxt_bresp;
  logic          rvalid_ff;
  logic          nxt_rvalid;
  logic [1:0]    rresp_ff;
  logic [1:0]    nxt_rresp;
  logic [31:0]   rdata_ff;
  logic [31:0]   nxt_rdata;

  // Register state
  logic          alt_table_select_ff;
  logic          nxt_alt_table_select;
  logic [NP-1:0] edge_pol_ff;
  logic [NP-1:0] nxt_edge_pol;
  logic [15:0]   flags_a_ff;
  logic [15:0]   nxt_flags_a;
  logic [15:0]   flags_b_ff;
  logic [15:0]   nxt_flags_b;
  logic [NP-1:0] pin_prev_ff;
  logic [NP-1:0] nxt_pin_prev;
  logic          irq_ff;
  logic          nxt_irq;

  // Decoded write and set terms
  logic          do_write;
  logic          wr_control;
  logic          wr_flags_a;
  logic          wr_flags_b;
  logic [15:0]   wr_mask;
  logic [15:0]   wr_val;
  logic [15:0]   control_view;
  logic [NP-1:0] pin_edge;
  logic [15:0]   hw_set_a;
  logic [15:0]   hw_set_b;

  // ==========================================================================
  // External pin edge detection
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      // Negative edge when polarity is one, positive edge otherwise
      assign pin_edge[gi] = edge_pol_ff[gi] ? (pin_prev_ff[gi] & ~EXT_PIN[gi])
                                            : (~pin_prev_ff[gi] & EXT_PIN[gi]);
    end
  endgenerate

  // Pins only reach their own flag positions
  always_comb begin
    hw_set_a = REQ_FLAGS_A;
    hw_set_b = REQ_FLAGS_B;
    hw_set_a[intflag_pkg::FA_EXT0] = pin_edge[0];
    hw_set_b[intflag_pkg::FB_EXT1] = pin_edge[1];
    hw_set_b[intflag_pkg::FB_EXT2] = pin_edge[2];
  end

  // ==========================================================================
  // Write path: address and data may arrive in either order
  assign S_AXI_AWREADY = ~aw_held_ff;
  assign S_AXI_WREADY  = ~w_held_ff;
  assign do_write      = aw_held_ff & w_held_ff & ~bvalid_ff;

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held  = w_held_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (S_AXI_AWVALID && !aw_held_ff) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_held_ff) begin
      nxt_w_held = 1'b1;
      nxt_w_data = S_AXI_WDATA;
      nxt_w_strb = S_AXI_WSTRB;
    end
    if (do_write) begin
      nxt_bvalid  = 1'b1;
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      case (aw_addr_ff)
        intflag_pkg::ADDR_CONTROL_TWO,
        intflag_pkg::ADDR_FLAGS_A,
        intflag_pkg::ADDR_FLAGS_B: nxt_bresp = intflag_pkg::RESP_OKAY;
        default:                   nxt_bresp = intflag_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_ff && S_AXI_BREADY) begin
      nxt_bvalid = 1'b0;
    end
  end

  // Byte enables cover the low 16 bits only
  always_comb begin
    wr_mask = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wr_val  = w_data_ff[15:0];
  end

  // ==========================================================================
  // Write decode, shared by the register groups below
  always_comb begin
    wr_control = do_write && (aw_addr_ff == intflag_pkg::ADDR_CONTROL_TWO);
    wr_flags_a = do_write && (aw_addr_ff == intflag_pkg::ADDR_FLAGS_A);
    wr_flags_b = do_write && (aw_addr_ff == intflag_pkg::ADDR_FLAGS_B);
  end

  // ==========================================================================
  // Control register two
  always_comb begin
    nxt_alt_table_select = alt_table_select_ff;
    nxt_edge_pol         = edge_pol_ff;
    // Hold bit and bits 13..3 are not writable
    if (wr_control && wr_mask[intflag_pkg::ALT_TABLE_BIT]) begin
      nxt_alt_table_select = wr_val[intflag_pkg::ALT_TABLE_BIT];
    end
    if (wr_control && wr_mask[intflag_pkg::EDGE_POL_LSB]) begin
      nxt_edge_pol = wr_val[intflag_pkg::EDGE_POL_LSB +: NP];
    end
  end

  // ==========================================================================
  // Flag registers A and B
  always_comb begin
    nxt_flags_a = flags_a_ff;
    nxt_flags_b = flags_b_ff;
    if (wr_flags_a) begin
      nxt_flags_a = (flags_a_ff & ~wr_mask) | (wr_val & wr_mask);
    end
    if (wr_flags_b) begin
      nxt_flags_b = (flags_b_ff & ~wr_mask) | (wr_val & wr_mask);
    end
    // A request in the same cycle as a software clear still wins,
    // so an event is never lost to a clear written in that same cycle
    nxt_flags_a = (nxt_flags_a | hw_set_a) & intflag_pkg::FLAGS_A_MASK;
    nxt_flags_b = (nxt_flags_b | hw_set_b) & intflag_pkg::FLAGS_B_MASK;
  end

  // ==========================================================================
  // Pin history and request output
  always_comb begin
    nxt_pin_prev = EXT_PIN;
    // Registered so the core never sees a glitch from a bus write
    nxt_irq = PRIORITY_OK & (|(flags_a_ff & ENABLE_A) | |(flags_b_ff & ENABLE_B));
  end

  // ==========================================================================
  // Read path
  always_comb begin
    control_view = intflag_pkg::CONTROL_RESET;
    control_view[intflag_pkg::ALT_TABLE_BIT] = alt_table_select_ff;
    control_view[intflag_pkg::HOLD_BIT]      = HOLD_INSTR_ACTIVE;
    control_view[intflag_pkg::EDGE_POL_LSB +: NP] = edge_pol_ff;
    control_view = control_view & intflag_pkg::CONTROL_WMASK | 
                   (control_view & (16'h0001 << intflag_pkg::HOLD_BIT));
  end

  assign S_AXI_ARREADY = ~rvalid_ff;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (S_AXI_ARVALID && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = intflag_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        intflag_pkg::ADDR_CONTROL_TWO: nxt_rdata = {16'h0000, control_view};
        intflag_pkg::ADDR_FLAGS_A:     nxt_rdata = {16'h0000, flags_a_ff};
        intflag_pkg::ADDR_FLAGS_B:     nxt_rdata = {16'h0000, flags_b_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = intflag_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && S_AXI_RREADY) begin
      nxt_rvalid = 1'b0;
    end
  end

  // ==========================================================================
  // Write bus registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= intflag_pkg::RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
      w_held_ff  <= nxt_w_held;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  // ==========================================================================
  // Read bus registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= intflag_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Control register two storage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      alt_table_select_ff <= 1'b0;
      edge_pol_ff         <= '0;
    end else begin
      alt_table_select_ff <= nxt_alt_table_select;
      edge_pol_ff         <= nxt_edge_pol;
    end
  end

  // ==========================================================================
  // Flag storage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      flags_a_ff <= intflag_pkg::FLAGS_RESET;
      flags_b_ff <= intflag_pkg::FLAGS_RESET;
    end else begin
      flags_a_ff <= nxt_flags_a;
      flags_b_ff <= nxt_flags_b;
    end
  end

  // ==========================================================================
  // Pin history and request storage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      // Tracks the live pins during reset: a pin already high at release is no edge
      pin_prev_ff <= EXT_PIN;
      irq_ff      <= 1'b0;
    end else begin
      pin_prev_ff <= nxt_pin_prev;
      irq_ff      <= nxt_irq;
    end
  end

  // ==========================================================================
  // Outputs
  assign S_AXI_BVALID     = bvalid_ff;
  assign S_AXI_BRESP      = bresp_ff;
  assign S_AXI_RVALID     = rvalid_ff;
  assign S_AXI_RRESP      = rresp_ff;
  assign S_AXI_RDATA      = rdata_ff;
  assign ALT_TABLE_SELECT = alt_table_select_ff;
  assign FLAGS_A          = flags_a_ff;
  assign FLAGS_B          = flags_b_ff;
  // Same registered level serves presentation and wake-up
  assign IRQ_PENDING      = irq_ff;
  assign WAKE_REQUEST     = irq_ff;

endmodule : intflag_ctrl

// *** verification/intflag_ctrl_properties.sv ***
// Concurrent checks on the ports of the interrupt flag block
`timescale 1ns/1ps
// ==========================================================================
// Checker
module intflag_ctrl_properties (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  // Bus
  input wire logic [3:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_BVALID,
  // Core and sources
  input wire logic        HOLD_INSTR_ACTIVE,
  input wire logic        ALT_TABLE_SELECT,
  input wire logic [15:0] REQ_FLAGS_A,
  input wire logic [15:0] REQ_FLAGS_B,
  input wire logic [15:0] ENABLE_A,
  input wire logic [15:0] ENABLE_B,
  input wire logic        PRIORITY_OK,
  input wire logic [15:0] FLAGS_A,
  input wire logic [15:0] FLAGS_B,
  input wire logic        IRQ_PENDING,
  input wire logic        WAKE_REQUEST
);
  // Pin-fed positions left out: those flags follow edges, not request inputs
  localparam logic [15:0] REQ_A_BITS = intflag_pkg::FLAGS_A_MASK & 16'hfffe;
  localparam logic [15:0] REQ_B_BITS = intflag_pkg::FLAGS_B_MASK & 16'hfffc;
  logic cause;
  assign cause = PRIORITY_OK && ((FLAGS_A & ENABLE_A) | (FLAGS_B & ENABLE_B)) != 16'h0000;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence rd_taken;
    S_AXI_ARVALID && !S_AXI_RVALID;
  endsequence
  sequence ctrl_answer;
    $rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) == intflag_pkg::ADDR_CONTROL_TWO;
  endsequence
  flags_a_zero_a: assert property ((FLAGS_A & ~intflag_pkg::FLAGS_A_MASK) == 16'h0000)
    else $error("flag A unused bit set");
  flags_b_zero_a: assert property ((FLAGS_B & ~intflag_pkg::FLAGS_B_MASK) == 16'h0000)
    else $error("flag B unused bit set");
  req_sets_a: assert property ($past(RST_N) |->
    ((FLAGS_A & $past(REQ_FLAGS_A) & REQ_A_BITS) == ($past(REQ_FLAGS_A) & REQ_A_BITS)) &&
    ((FLAGS_B & $past(REQ_FLAGS_B) & REQ_B_BITS) == ($past(REQ_FLAGS_B) & REQ_B_BITS)))
    else $error("request did not set its flag");
  sticky_flag_a: assert property ($past(RST_N) && ((($past(FLAGS_A) & ~FLAGS_A) != 0) ||
    (($past(FLAGS_B) & ~FLAGS_B) != 0)) |-> $rose(S_AXI_BVALID))
    else $error("flag cleared without a write");
  alt_by_write_a: assert property ($past(RST_N) && $changed(ALT_TABLE_SELECT) |->
    $rose(S_AXI_BVALID))
    else $error("table select moved without a write");
  irq_cause_a: assert property ($past(RST_N) |->
    IRQ_PENDING == $past(cause) && WAKE_REQUEST == IRQ_PENDING)
    else $error("request or wake output wrong");
  read_answer_a: assert property (rd_taken |=> S_AXI_RVALID)
    else $error("read not answered");
  ctrl_read_a: assert property (ctrl_answer |-> {S_AXI_RDATA[31:16], S_AXI_RDATA[14:3]} ==
    {16'h0000, $past(HOLD_INSTR_ACTIVE), 11'h000})
    else $error("control read bits wrong");
endmodule : intflag_ctrl_properties

bind intflag_ctrl intflag_ctrl_properties intflag_ctrl_properties_inst (.*);

// *** verification/intflag_source_model.sv ***
// Behavioural peripheral sources and external pins
`timescale 1ns/1ps
// ==========================================================================
// Source model
module intflag_source_model (
  // Clock
  input  wire logic clk,
  // Toward the block
  output logic [15:0] req_a,
  output logic [15:0] req_b,
  output logic [2:0]  pins
);
  initial begin
    req_a = 16'h0000;
    req_b = 16'h0000;
    pins = 3'h0;
  end
  // One-cycle pulses, as a peripheral event gives them
  task automatic pulse(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    req_a <= a;
    req_b <= b;
    @(posedge clk);
    req_a <= 16'h0000;
    req_b <= 16'h0000;
  endtask : pulse
  task automatic drive_pins(input logic [2:0] v);
    @(posedge clk);
    pins <= v;
  endtask : drive_pins
endmodule : intflag_source_model

// *** verification/interrupt_flag_and_edge_control_test.sv ***
// Self-checking bench for the interrupt flag and edge control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
// ==========================================================================
// Bench top
module interrupt_flag_and_edge_control_test;
  logic        CLK_SYS = 1'b0, RST_N = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic        S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        HOLD_INSTR_ACTIVE = 1'b0, PRIORITY_OK = 1'b0;
  logic [3:0]  S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rnd;
  logic [15:0] ENABLE_A = 16'h0, ENABLE_B = 16'h0, REQ_FLAGS_A, REQ_FLAGS_B, FLAGS_A, FLAGS_B;
  logic [2:0]  EXT_PIN, pol[3] = '{3'h0, 3'h7, 3'h5};
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        ALT_TABLE_SELECT, IRQ_PENDING, WAKE_REQUEST, exp_irq;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [3:0]  adr[3] = '{intflag_pkg::ADDR_CONTROL_TWO, intflag_pkg::ADDR_FLAGS_A,
                          intflag_pkg::ADDR_FLAGS_B};
  logic [15:0] msk[3] = '{intflag_pkg::CONTROL_WMASK, intflag_pkg::FLAGS_A_MASK,
                          intflag_pkg::FLAGS_B_MASK};
  logic [15:0] mdl[3] = '{16'h0, 16'h0, 16'h0};
  int          error_cnt = 0, n_compared = 0, cyc = 0, seed = 55593;

  intflag_ctrl intflag_ctrl_inst (.*);
  intflag_source_model src (.clk(CLK_SYS), .req_a(REQ_FLAGS_A), .req_b(REQ_FLAGS_B),
                            .pins(EXT_PIN));
  always #50 CLK_SYS = ~CLK_SYS;
  // Whole run needs well under 3000 cycles
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    `CHK("bresp", er, S_AXI_BRESP)
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    `CHK("rresp", er, S_AXI_RRESP)
    `CHK("rdata", e, S_AXI_RDATA)
  endtask : rd

  task automatic wr_reg(input int i, input logic [31:0] d);
    wr(adr[i], d, intflag_pkg::RESP_OKAY);
    mdl[i] = d[15:0] & msk[i];
  endtask : wr_reg

  task automatic rd_reg(input int i);
    logic [31:0] e;
    e = {16'h0000, mdl[i]};
    if (i == 0) e[14] = HOLD_INSTR_ACTIVE;
    rd(adr[i], e, intflag_pkg::RESP_OKAY);
  endtask : rd_reg

  initial begin
    repeat (12) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    for (int i = 0; i < 3; i++) rd_reg(i);
    rd(4'hc, 32'h0, intflag_pkg::RESP_SLVERR);
    wr(4'hc, 32'hffff, intflag_pkg::RESP_SLVERR);
    $display("test reset and unmapped done");
    for (int k = 0; k < 8; k++) begin
      rnd = $random(seed);
      ENABLE_A <= rnd[15:0];
      ENABLE_B <= rnd[31:16];
      HOLD_INSTR_ACTIVE <= rnd[5];
      PRIORITY_OK <= rnd[9];
      for (int i = 0; i < 3; i++) begin
        rnd = (k == 0) ? 32'hffffffff : $random(seed);
        wr_reg(i, rnd);
        rd_reg(i);
      end
      `CHK("alt", mdl[0][15], ALT_TABLE_SELECT)
      exp_irq = PRIORITY_OK && ((mdl[1] & ENABLE_A) | (mdl[2] & ENABLE_B)) != 16'h0000;
      `CHK("irq", {2{exp_irq}}, {IRQ_PENDING, WAKE_REQUEST})
    end
    $display("test register access done");
    wr_reg(1, 32'h0);
    wr_reg(2, 32'h0);
    for (int b = 0; b < 16; b++) begin
      src.pulse(16'h0001 << b, 16'h0001 << b);
      repeat (2) @(posedge CLK_SYS);
      mdl[1] |= (16'h0001 << b) & msk[1] & 16'hfffe;
      mdl[2] |= (16'h0001 << b) & msk[2] & 16'hfffc;
      `CHK("flags", {mdl[1], mdl[2]}, {FLAGS_A, FLAGS_B})
    end
    rd_reg(1);
    rd_reg(2);
    $display("test source flags done");
    for (int p = 0; p < 3; p++) begin
      wr_reg(0, {29'h0, pol[p]});
      src.drive_pins(pol[p]);
      repeat (2) @(posedge CLK_SYS);
      wr_reg(1, 32'h0);
      wr_reg(2, 32'h0);
      src.drive_pins(~pol[p]);
      repeat (3) @(posedge CLK_SYS);
      `CHK("edge", 3'h7, {FLAGS_B[1:0], FLAGS_A[0]})
      wr_reg(1, 32'h0);
      wr_reg(2, 32'h0);
      src.drive_pins(pol[p]);
      repeat (3) @(posedge CLK_SYS);
      `CHK("no edge", 3'h0, {FLAGS_B[1:0], FLAGS_A[0]})
    end
    $display("test pin polarity done");
    summarize();
  end
endmodule : interrupt_flag_and_edge_control_test
